// ==== logic/lcs_pkg.sv ====
// Shared constants and types for the layer combine and fine scroll block
package lcs_pkg;

	// Register indices; each register takes one word at four times its index
	localparam logic [7:0]  LCS_IDX_ATTR     = 8'h0a;
	localparam logic [7:0]  LCS_IDX_COMBINE  = 8'h18;
	localparam logic [7:0]  LCS_IDX_HOFFSET  = 8'h1b;
	localparam logic [7:0]  LCS_IDX_MODE     = 8'h1e;
	localparam logic [7:0]  LCS_IDX_STATUS   = 8'h1f;
	localparam int          LCS_ADDR_W       = 10;

	// Reset values; a cleared combine register selects OR merging
	localparam logic [7:0]  LCS_RST_ATTR     = 8'h00;
	localparam logic [7:0]  LCS_RST_COMBINE  = 8'h00;
	localparam logic [2:0]  LCS_RST_HOFFSET  = 3'h0;
	localparam logic [1:0]  LCS_RST_MODE     = 2'h0;

	// Field positions
	localparam int          LCS_HOFF_LSB     = 0;
	localparam int          LCS_HOFF_W       = 3;
	localparam int          LCS_SEL_LSB      = 0;
	localparam int          LCS_SEL_W        = 2;
	localparam int          LCS_ATTR_L1_LSB  = 0;
	localparam int          LCS_ATTR_L2_LSB  = 2;
	localparam int          LCS_ATTR_L3_LSB  = 4;
	localparam int          LCS_STAT_OFF_LSB = 0;
	localparam int          LCS_STAT_SEL_LSB = 3;
	localparam int          LCS_STAT_BPP_LSB = 5;
	localparam int          LCS_STAT_FRM_LSB = 8;

	// Layer merge functions
	localparam logic [1:0]  LCS_SEL_OR       = 2'h0;
	localparam logic [1:0]  LCS_SEL_XOR      = 2'h1;
	localparam logic [1:0]  LCS_SEL_AND      = 2'h2;
	localparam logic [1:0]  LCS_SEL_PRIOR    = 2'h3;

	// Per layer display codes held in each two-bit attribute field
	localparam logic [1:0]  LCS_LAY_OFF      = 2'h0;
	localparam logic [1:0]  LCS_LAY_ON       = 2'h1;
	localparam logic [1:0]  LCS_LAY_SLOW     = 2'h2;
	localparam logic [1:0]  LCS_LAY_FAST     = 2'h3;

	// Blink phases as frame counter bits: bit 1 gives frame rate / 4,
	// about 17 Hz at 70 Hz frames; bit 4 gives frame rate / 32, about 2 Hz
	localparam int          LCS_FAST_BIT     = 1;
	localparam int          LCS_SLOW_BIT     = 4;
	localparam int          LCS_FRM_W        = 8;

	// Pixel depth of the panel data
	typedef enum logic [1:0] {
		LCS_BPP1,
		LCS_BPP2,
		LCS_BPP4
	} lcs_bpp_t;

endpackage

// ==== logic/lcs_blink_timer.sv ====
// Frame counter and blink phases for the layer flash attribute
`timescale 1ns/100ps
module lcs_blink_timer
	import lcs_pkg::*;
#(
	parameter int FRM_W = LCS_FRM_W
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             frame_start,
	output logic [FRM_W-1:0]      frame_cnt,
	output logic                  blink_fast,
	output logic                  blink_slow
);

	logic [FRM_W-1:0] cnt_q;
	logic [FRM_W-1:0] cnt_d;

	// Count frames; blinking is tied to frames so a flash never tears
	assign cnt_d = frame_start ? cnt_q + 1'b1 : cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign frame_cnt  = cnt_q;
	assign blink_fast = cnt_q[LCS_FAST_BIT];
	assign blink_slow = cnt_q[LCS_SLOW_BIT];

endmodule

// ==== logic/lcs_layer_merge.sv ====
// Per layer flash gating and logic merge of three layers
`timescale 1ns/100ps
module lcs_layer_merge
	import lcs_pkg::*;
#(
	parameter int PIX_W = 8
) (
	input  wire logic [PIX_W-1:0] layer1,
	input  wire logic [PIX_W-1:0] layer2,
	input  wire logic [PIX_W-1:0] layer3,
	input  wire logic [7:0]       attr,
	input  wire logic [1:0]       sel,
	input  wire logic             blink_fast,
	input  wire logic             blink_slow,
	output logic [PIX_W-1:0]      merged
);

	// Layer visibility from its two-bit field and the blink phases
	function automatic logic visible(input logic [1:0] code,
	                                 input logic fast, input logic slow);
		case (code)
			LCS_LAY_ON:   visible = 1'b1;
			LCS_LAY_SLOW: visible = slow;
			LCS_LAY_FAST: visible = fast;
			default:      visible = 1'b0;
		endcase
	endfunction

	// One merge step; priority OR equals plain OR on single-bit pixels
	function automatic logic [PIX_W-1:0] merge(input logic [1:0] s,
	                                           input logic [PIX_W-1:0] a,
	                                           input logic [PIX_W-1:0] b);
		case (s)
			LCS_SEL_XOR:   merge = a ^ b;
			LCS_SEL_AND:   merge = a & b;
			LCS_SEL_PRIOR: merge = a | b;
			default:       merge = a | b;
		endcase
	endfunction

	wire        vis1 = visible(attr[LCS_ATTR_L1_LSB +: 2], blink_fast,
	                           blink_slow);
	wire        vis2 = visible(attr[LCS_ATTR_L2_LSB +: 2], blink_fast,
	                           blink_slow);
	wire        vis3 = visible(attr[LCS_ATTR_L3_LSB +: 2], blink_fast,
	                           blink_slow);
	wire [PIX_W-1:0] g1 = vis1 ? layer1 : '0;
	wire [PIX_W-1:0] g2 = vis2 ? layer2 : '0;
	wire [PIX_W-1:0] g3 = vis3 ? layer3 : '0;
	wire [PIX_W-1:0] m12 = merge(sel, g1, g2);

	// Third layer is merged last with the same function
	assign merged = merge(sel, m12, g3);

endmodule

// ==== logic/lcs_layer_combine_fine_scroll.sv ====
// Layer combine and fine horizontal scroll with its AHB-Lite registers
//
// Functional notes
// - Three-bit pixel offset at index 1Bh bits 2-0 shifts the display.
// - Offset applies to the merged image, never to one layer alone.
// - Fine offset works only at 1 bpp; 2 and 4 bpp ignore it.
// - Inverse, half-tone and flash come from registers 18h and 0Ah.
// - Select field 01 in register 18h merges layers by exclusive-OR.
// - Attribute flags 0 and 2 set show layers one and two steadily.
// - Combine register zero merges layers by logical OR.
// - Per layer flash at about 17 Hz; with a steady layer gives half-tone.
`timescale 1ns/100ps
module lcs_layer_combine_fine_scroll
	import lcs_pkg::*;
#(
	parameter int PIX_W = 8,
	parameter int FRM_W = LCS_FRM_W
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	// AHB-Lite slave
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	// Layer pixel stream, one byte per layer, leftmost pixel in the MSB
	input  wire logic             frame_start,
	input  wire logic             pix_in_valid,
	input  wire logic [PIX_W-1:0] layer1_pix,
	input  wire logic [PIX_W-1:0] layer2_pix,
	input  wire logic [PIX_W-1:0] layer3_pix,
	output logic                  pix_out_valid,
	output logic [PIX_W-1:0]      pix_out
);

	localparam logic [LCS_ADDR_W-1:0] A_ATTR =
		LCS_ADDR_W'({LCS_IDX_ATTR, 2'b00});
	localparam logic [LCS_ADDR_W-1:0] A_COMBINE =
		LCS_ADDR_W'({LCS_IDX_COMBINE, 2'b00});
	localparam logic [LCS_ADDR_W-1:0] A_HOFFSET =
		LCS_ADDR_W'({LCS_IDX_HOFFSET, 2'b00});
	localparam logic [LCS_ADDR_W-1:0] A_MODE =
		LCS_ADDR_W'({LCS_IDX_MODE, 2'b00});
	localparam logic [LCS_ADDR_W-1:0] A_STATUS =
		LCS_ADDR_W'({LCS_IDX_STATUS, 2'b00});

	// Software visible registers
	logic [7:0]            attr_q;
	logic [7:0]            attr_d;
	logic [7:0]            combine_q;
	logic [7:0]            combine_d;
	logic [2:0]            hoff_q;
	logic [2:0]            hoff_d;
	logic [1:0]            mode_q;
	logic [1:0]            mode_d;
	// Frame-aligned copies that the pixel path uses
	logic [7:0]            attr_act_q;
	logic [1:0]            sel_act_q;
	logic [2:0]            off_act_q;
	logic [1:0]            mode_act_q;
	// Bus data phase state
	logic                  wr_pend_q;
	logic [LCS_ADDR_W-1:0] wr_addr_q;
	logic [31:0]           rdata_q;
	logic [31:0]           rdata_d;
	// Pixel path
	logic [PIX_W-1:0]      prev_q;
	logic [PIX_W-1:0]      out_q;
	logic                  out_vld_q;
	logic [FRM_W-1:0]      frame_cnt;
	logic                  blink_fast;
	logic                  blink_slow;
	logic [PIX_W-1:0]      merged;

	// Address phase decode; only whole-word transfers are mapped
	wire                  take     = hsel & hready & htrans[1];
	wire [LCS_ADDR_W-1:0] a_addr   = haddr[LCS_ADDR_W-1:0];
	wire                  is_word  = (hsize == 3'h2);
	wire                  take_rd  = take & ~hwrite;
	wire                  take_wr  = take & hwrite & is_word;

	// Data phase write strobes per register
	wire wr_attr    = wr_pend_q & (wr_addr_q == A_ATTR);
	wire wr_combine = wr_pend_q & (wr_addr_q == A_COMBINE);
	wire wr_hoff    = wr_pend_q & (wr_addr_q == A_HOFFSET);
	wire wr_mode    = wr_pend_q & (wr_addr_q == A_MODE);

	// Zero wait state slave with OKAY answers only
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	// Register next values from the write data phase
	assign attr_d    = wr_attr    ? hwdata[7:0] : attr_q;
	assign combine_d = wr_combine ? hwdata[7:0] : combine_q;
	assign hoff_d    = wr_hoff ? hwdata[LCS_HOFF_LSB +: LCS_HOFF_W]
	                           : hoff_q;
	assign mode_d    = wr_mode    ? hwdata[1:0] : mode_q;

	// Status word shows the offset, select and depth in force and the frame count
	wire [31:0] status_w = {{(32-LCS_STAT_FRM_LSB-FRM_W){1'b0}}, frame_cnt,
	                        1'b0, mode_act_q, sel_act_q, off_act_q};

	// Read mux sees the register next values, so a read right after a
	// write returns the new contents without an extra wait state
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (take_rd && is_word) begin
			case (a_addr)
				A_ATTR:    rdata_d = {24'h00_0000, attr_d};
				A_COMBINE: rdata_d = {24'h00_0000, combine_d};
				A_HOFFSET: rdata_d = {29'h0000_0000, hoff_d};
				A_MODE:    rdata_d = {30'h0000_0000, mode_d};
				A_STATUS:  rdata_d = status_w;
				default:   rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Write request held over into its data phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= take_wr;
		end
	end

	// Write address; only looked at while wr_pend_q is set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_addr_q <= '0;
		end else begin
			wr_addr_q <= a_addr;
		end
	end

	// Read data register; zero in every cycle without a read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Software registers; unmapped writes are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			attr_q <= LCS_RST_ATTR;
		end else begin
			attr_q <= attr_d;
		end
	end

	// Combine register; a cleared value selects OR merging
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			combine_q <= LCS_RST_COMBINE;
		end else begin
			combine_q <= combine_d;
		end
	end

	// Pixel offset register, three bits wide
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hoff_q <= LCS_RST_HOFFSET;
		end else begin
			hoff_q <= hoff_d;
		end
	end

	// Pixel depth register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= LCS_RST_MODE;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Settings move to the pixel path only at a frame start, so no frame
	// shows half an update; a write in that same cycle is taken as well
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			attr_act_q <= LCS_RST_ATTR;
		end else if (frame_start) begin
			attr_act_q <= attr_d;
		end
	end

	// Merge select in force for the current frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_act_q <= LCS_RST_COMBINE[LCS_SEL_LSB +: LCS_SEL_W];
		end else if (frame_start) begin
			sel_act_q <= combine_d[LCS_SEL_LSB +: LCS_SEL_W];
		end
	end

	// Offset in force for the current frame; a change mid-frame would
	// tear the picture at the byte where it landed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			off_act_q <= LCS_RST_HOFFSET;
		end else if (frame_start) begin
			off_act_q <= hoff_d;
		end
	end

	// Pixel depth in force for the current frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_act_q <= LCS_RST_MODE;
		end else if (frame_start) begin
			mode_act_q <= mode_d;
		end
	end

	lcs_blink_timer #(
		.FRM_W       (FRM_W)
	) u_timer (
		.clk         (clk),
		.rst_n       (rst_n),
		.frame_start (frame_start),
		.frame_cnt   (frame_cnt),
		.blink_fast  (blink_fast),
		.blink_slow  (blink_slow)
	);

	lcs_layer_merge #(
		.PIX_W       (PIX_W)
	) u_merge (
		.layer1      (layer1_pix),
		.layer2      (layer2_pix),
		.layer3      (layer3_pix),
		.attr        (attr_act_q),
		.sel         (sel_act_q),
		.blink_fast  (blink_fast),
		.blink_slow  (blink_slow),
		.merged      (merged)
	);

	// The offset counts only at one bit per pixel; deeper modes would
	// split a pixel across the shift, so they run with no offset
	wire        fine_ok = (mode_act_q == LCS_BPP1);
	wire [2:0]  eff_off = fine_ok ? off_act_q : 3'h0;

	// Shift window over the previous and current merged bytes; one shift
	// on the whole merged image, never per layer
	wire [2*PIX_W-1:0] pair    = {prev_q, merged};
	wire [2*PIX_W-1:0] shifted = pair << eff_off;

	// Output strobe, one cycle per taken byte; bytes that arrive with
	// the frame start are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_vld_q <= 1'b0;
		end else begin
			out_vld_q <= pix_in_valid & ~frame_start;
		end
	end

	// Previous merged byte; cleared so a frame never borrows pixels
	// from the one before it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
		end else if (frame_start) begin
			prev_q <= '0;
		end else if (pix_in_valid) begin
			prev_q <= merged;
		end
	end

	// Output byte; lags the input by one byte so that pixels pulled in
	// from the next byte are already at hand
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= '0;
		end else if (frame_start) begin
			out_q <= '0;
		end else if (pix_in_valid) begin
			out_q <= shifted[2*PIX_W-1:PIX_W];
		end
	end

	assign pix_out_valid = out_vld_q;
	assign pix_out       = out_q;

endmodule

// ==== tb/lcs_checker.sv ====
// Port checker for the layer combine and fine scroll block
`timescale 1ns/100ps
module lcs_checker #(
	parameter int PIX_W = 8,
	parameter int FRM_W = 8
) (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             hsel,
	input wire logic [31:0]      haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic [2:0]       hsize,
	input wire logic             hready,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic [31:0]      hrdata,
	input wire logic             frame_start,
	input wire logic             pix_in_valid,
	input wire logic [PIX_W-1:0] layer1_pix,
	input wire logic [PIX_W-1:0] layer2_pix,
	input wire logic [PIX_W-1:0] layer3_pix,
	input wire logic             pix_out_valid,
	input wire logic [PIX_W-1:0] pix_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Taken byte, taken read and mapped word decode
	wire       tk = pix_in_valid && !frame_start;
	wire       rq = hsel && hready && htrans[1] && !hwrite;
	wire [9:0] a  = haddr[9:0];
	wire       mp = a == 10'h028 || a == 10'h060 || a == 10'h06c
		|| a == 10'h078 || a == 10'h07c;
	wire       zl = layer1_pix == '0 && layer2_pix == '0 && layer3_pix == '0;

	a_ready_high: assert property (hreadyout == 1'h1)
		else $error("hreadyout not high");
	a_resp_okay: assert property (hresp == 1'h0)
		else $error("hresp not okay");
	a_byte_answer: assert property (tk |=> pix_out_valid)
		else $error("taken byte gave no output");
	a_no_extra_out: assert property (!tk |=> !pix_out_valid)
		else $error("output without a taken byte");
	a_out_holds: assert property (!pix_in_valid && !frame_start |=>
		$stable(pix_out))
		else $error("pix_out moved without input");
	a_frame_clear: assert property (frame_start |=> pix_out == '0)
		else $error("pix_out not cleared at frame start");
	a_fresh_frame: assert property (frame_start ##1 (tk && zl) |=>
		pix_out == '0)
		else $error("history not cleared at frame start");
	a_idle_rdata: assert property (!rq |=> hrdata == 32'h0)
		else $error("hrdata not zero without read");
	a_unmapped_zero: assert property (
		rq && (!mp || hsize != 3'h2) |=> hrdata == 32'h0)
		else $error("unmapped or narrow read not zero");
	a_offset_width: assert property (rq && a == 10'h06c |=>
		hrdata[31:3] == 29'h0)
		else $error("offset read wider than three bits");
	a_combine_width: assert property (rq && a == 10'h060 |=>
		hrdata[31:8] == 24'h0)
		else $error("combine read wider than a byte");
endmodule

bind lcs_layer_combine_fine_scroll lcs_checker #(.PIX_W(PIX_W), .FRM_W(FRM_W))
	u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.frame_start(frame_start), .pix_in_valid(pix_in_valid),
	.layer1_pix(layer1_pix), .layer2_pix(layer2_pix),
	.layer3_pix(layer3_pix), .pix_out_valid(pix_out_valid),
	.pix_out(pix_out));

// ==== tb/lcs_host.sv ====
// Host processor model issuing single register transfers of word or narrower size
`timescale 1ns/100ps
module lcs_host (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	logic [31:0] rd_q;
	int          tmo = 0;
	// Idle bus at time zero
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	end
	// Read data as it stood at the edge closing the data phase
	always @(posedge clk) rd_q <= hrdata;
	// Address phase held until hready, then data phase held until hready
	task automatic xfer(input logic w, input logic [31:0] ad,
		input logic [31:0] d, input logic [2:0] s, output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'h1;
		haddr <= ad;
		hwrite <= w;
		hsize <= s;
		htrans <= 2'h2;
		do begin @(posedge clk); n++; end while (hready !== 1'h1 && n < 20);
		if (hready !== 1'h1) tmo++;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		n = 0;
		do begin @(posedge clk); n++; end while (hready !== 1'h1 && n < 20);
		if (hready !== 1'h1) tmo++;
		#1 r = rd_q;
	endtask
endmodule

// ==== tb/lcs_layer_combine_fine_scroll_tb.sv ====
// Self-checking bench for the layer combine and fine scroll block
`timescale 1ns/100ps
module lcs_layer_combine_fine_scroll_tb import lcs_pkg::*;;
	logic        clk = 0, rst_n = 0, frame_start = 0, pix_in_valid = 0;
	logic [7:0]  layer1_pix = 0, layer2_pix = 0, layer3_pix = 0;
	logic        hsel, hwrite, hreadyout, hresp, pix_out_valid;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [7:0]  pix_out, sh_attr, sh_sel, sh_off, sh_mode;
	logic [7:0]  got[$], exp_q[$];
	int          num_errors = 0, num_checks = 0, nfr = 0, cnt;

	always #2 clk = ~clk;
	// Collect every output byte as it stands
	always @(posedge clk) if (pix_out_valid === 1'h1) got.push_back(pix_out);

	lcs_layer_combine_fine_scroll uut (.clk(clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.frame_start(frame_start), .pix_in_valid(pix_in_valid),
		.layer1_pix(layer1_pix), .layer2_pix(layer2_pix),
		.layer3_pix(layer3_pix), .pix_out_valid(pix_out_valid),
		.pix_out(pix_out));
	lcs_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		num_checks++;
		if (seen !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task wreg(input logic [7:0] i, input logic [31:0] d);
		host.xfer(1'h1, {22'h0, i, 2'h0}, d, 3'h2, r);
	endtask
	task rreg(input string nm, input logic [7:0] i, input logic [31:0] e);
		host.xfer(1'h0, {22'h0, i, 2'h0}, 32'h0, 3'h2, r);
		chk(nm, r, e);
	endtask
	// Settings are shadowed only once all four writes have landed
	task cfg(input logic [7:0] a, s, o, m);
		wreg(LCS_IDX_ATTR, {24'h0, a});
		wreg(LCS_IDX_COMBINE, {24'h0, s});
		wreg(LCS_IDX_HOFFSET, {24'h0, o});
		wreg(LCS_IDX_MODE, {24'h0, m});
		{sh_attr, sh_sel, sh_off, sh_mode} = {a, s, o, m};
	endtask
	// Gate hidden layers to blank, then merge with the selected function
	function automatic logic [7:0] mrg(input logic [7:0] a, b, c, at,
		input logic [1:0] s);
		a = at[1:0] == LCS_LAY_ON ? a : 8'h00;
		b = at[3:2] == LCS_LAY_ON ? b : 8'h00;
		c = at[5:4] == LCS_LAY_ON ? c : 8'h00;
		if (s == LCS_SEL_XOR) return a ^ b ^ c;
		if (s == LCS_SEL_AND) return a & b & c;
		return a | b | c;
	endfunction
	// One frame; f picks random bytes, a blank first byte or a lit one
	task frame(input int n, input int f);
		logic [7:0]  at, sl, of, pv, m;
		logic [15:0] t;
		logic [31:0] rv;
		@(posedge clk);
		frame_start <= 1'h1;
		{at, sl, pv} = {sh_attr, sh_sel, 8'h00};
		of = sh_mode == 8'h00 ? sh_off : 8'h00;
		nfr++;
		got.delete();
		exp_q.delete();
		for (int i = 0; i < n; i++) begin
			rv = (i > 0 || f == 0) ? $urandom
			     : (f == 1 ? 32'h0 : 32'hffffffff);
			@(posedge clk);
			frame_start <= 1'h0;
			pix_in_valid <= 1'h1;
			{layer3_pix, layer2_pix, layer1_pix} <= rv[23:0];
			m = mrg(rv[7:0], rv[15:8], rv[23:16], at, sl[1:0]);
			t = {pv, m} << of[2:0];
			exp_q.push_back(t[15:8]);
			pv = m;
		end
		@(posedge clk);
		frame_start <= 1'h0;
		pix_in_valid <= 1'h0;
		repeat (2) @(posedge clk);
	endtask
	task run(input int n, input int f);
		frame(n, f);
		chk("byte count", got.size(), exp_q.size());
		foreach (exp_q[i]) chk("pix_out", got[i], exp_q[i]);
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'hbd66));
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		// Settle pause before the first setting, scaled to keep runs short
		repeat (2) @(posedge clk);
		rreg("attr reset", LCS_IDX_ATTR, LCS_RST_ATTR);
		rreg("combine reset", LCS_IDX_COMBINE, LCS_RST_COMBINE);
		rreg("offset reset", LCS_IDX_HOFFSET, LCS_RST_HOFFSET);
		rreg("status reset", LCS_IDX_STATUS, 32'h0);
		wreg(LCS_IDX_HOFFSET, 32'hffffffff);
		rreg("offset field", LCS_IDX_HOFFSET, 32'h7);
		host.xfer(1'h1, 32'h6c, 32'h2, 3'h0, r);
		rreg("narrow write", LCS_IDX_HOFFSET, 32'h7);
		host.xfer(1'h0, 32'h6c, 32'h0, 3'h0, r);
		chk("narrow read", r, 32'h0);
		wreg(LCS_IDX_COMBINE, 32'h123456a5);
		rreg("combine field", LCS_IDX_COMBINE, 32'ha5);
		wreg(LCS_IDX_ATTR, 32'hffffff3c);
		rreg("attr field", LCS_IDX_ATTR, 32'h3c);
		wreg(8'h05, 32'hffffffff);
		rreg("unmapped", 8'h05, 32'h0);
		for (int s = 0; s < 4; s++) for (int o = 0; o < 8; o++) begin
			cfg(8'h15, 8'(s), 8'(o), 8'h00);
			run(4, 0);
		end
		for (int o = 7; o >= 0; o--) begin
			cfg(8'h15, 8'h01, 8'(o), 8'h00);
			run(3, 0);
		end
		cfg(8'h05, {6'h0, LCS_SEL_XOR}, 8'h00, 8'h00);
		run(6, 1);
		for (int m = 1; m < 3; m++) begin
			cfg(8'h15, 8'h00, 8'h05, 8'(m));
			run(4, 0);
		end
		cfg(8'h15, 8'h00, 8'h03, 8'h00);
		fork
			run(12, 0);
			begin @(posedge clk); cfg(8'h15, 8'h01, 8'h06, 8'h00); end
		join
		run(4, 0);
		cfg(8'h03, 8'h00, 8'h00, 8'h00);
		cnt = 0;
		// First output byte is blank history; the lit byte comes second
		repeat (4) begin
			frame(2, 2);
			cnt += (got[1] === 8'hff);
		end
		chk("blink lit frames", cnt, 2);
		rreg("status", LCS_IDX_STATUS, {16'h0, nfr[7:0], 8'h00});
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		rreg("attr after reset", LCS_IDX_ATTR, LCS_RST_ATTR);
		chk("bus waits", host.tmo, 0);
		results();
	end
	// Watchdog on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule
